// ==== dcp_pkg.sv ====
// Shared types, constants and helpers of the diskette command interpreter.
package dcp_pkg;
  typedef enum logic [3:0] {
    CMD_RDATA, CMD_RDEL, CMD_RTRK, CMD_RID, CMD_WDATA, CMD_WDEL, CMD_FMT,
    CMD_RECAL, CMD_SINT, CMD_SPEC, CMD_SDRV, CMD_SEEK, CMD_BAD
  } dcp_cmd_t;
  typedef enum logic [2:0] {PH_CMD, PH_PAR, PH_EXEC, PH_STEP, PH_RES} dcp_phase_t;
  typedef enum logic [1:0] {SP_IDLE, SP_CHECK, SP_PULSE, SP_GAP} dcp_step_t;

  // Opcode fields in bits 4..0 of the first byte; the whole first byte for recal, interrupt, specify, drive and seek
  localparam logic [4:0] OPC_RDATA = 5'h06;
  localparam logic [4:0] OPC_RDEL = 5'h0C;
  localparam logic [4:0] OPC_RTRK = 5'h02;
  localparam logic [4:0] OPC_RID = 5'h0A;
  localparam logic [4:0] OPC_WDATA = 5'h05;
  localparam logic [4:0] OPC_WDEL = 5'h09;
  localparam logic [4:0] OPC_FMT = 5'h0D;
  localparam logic [7:0] OPC_RECAL = 8'h07;
  localparam logic [7:0] OPC_SINT = 8'h08;
  localparam logic [7:0] OPC_SPEC = 8'h03;
  localparam logic [7:0] OPC_SDRV = 8'h04;
  localparam logic [7:0] OPC_SEEK = 8'h0F;
  localparam logic [7:0] MASK_Z75 = 8'hA0;
  localparam int MT_BIT = 7;
  localparam int MF_BIT = 6;
  localparam int SK_BIT = 5;
  localparam int HD_BIT = 2;

  // Termination codes
  localparam logic [1:0] TC_NORMAL = 2'h0;
  localparam logic [1:0] TC_FAILED = 2'h1;
  localparam logic [1:0] TC_INVALID = 2'h2;

  // Parameter byte counts after the opcode, result byte counts
  localparam logic [3:0] LEN_XFER = 4'h8;
  localparam logic [3:0] LEN_FMT = 4'h5;
  localparam logic [3:0] LEN_TWO = 4'h2;
  localparam logic [3:0] LEN_ONE = 4'h1;
  localparam logic [3:0] LEN_NONE = 4'h0;
  localparam logic [2:0] RES_XFER = 3'h7;
  localparam logic [2:0] RES_SINT = 3'h2;
  localparam logic [2:0] RES_ONE = 3'h1;

  localparam logic [6:0] RECAL_MAX_STEPS = 7'h50;
  localparam int CLK_MHZ = 25;
  localparam int STEP_PULSE_NS = 1000;
  localparam int STEP_PULSE_CYC = (STEP_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / 1000 * CLK_MHZ;

  function automatic logic [7:0] dcp_st0(input logic [1:0] tc, input logic se,
                                         input logic ec, input logic hd,
                                         input logic [1:0] drv);
    dcp_st0 = {tc, se, ec, 1'b0, hd, drv};
  endfunction
endpackage

// ==== dcp_fifo.sv ====
// Command byte FIFO between the host data port and the interpreter.
`timescale 1ns/10ps
module dcp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign level = cnt_r;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
    end
    if (pop) begin
      rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - (AW+1)'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
endmodule // dcp_fifo

// ==== dcp_stepper.sv ====
// Head step sequencer for seek and recalibrate.
`timescale 1ns/10ps
module dcp_stepper #(
  parameter int MS_CYC = dcp_pkg::MS_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic recal,
  input wire logic [7:0] cur,
  input wire logic [7:0] tgt,
  input wire logic [3:0] rate,
  input wire logic track_zero,
  output logic step_r,
  output logic dir_r,
  output logic done_r,
  output logic fault_r,
  output logic [7:0] pos_r
);
  import dcp_pkg::*;
  localparam int TW = $clog2(16 * MS_CYC + STEP_PULSE_CYC + 1);
  dcp_step_t st_r, st_nxt;
  logic [TW-1:0] tmr_r, tmr_nxt;
  logic [6:0] nst_r, nst_nxt;
  logic [7:0] tgt_r, tgt_nxt, pos_nxt;
  logic rec_r, rec_nxt, step_nxt, dir_nxt, done_nxt, fault_nxt;
  logic [4:0] gap_ms;

  // A zero step-rate field stands for the slowest rate
  assign gap_ms = (rate == 4'h0) ? 5'h10 : 5'h10 - {1'b0, rate};

  always_comb begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    nst_nxt = nst_r;
    tgt_nxt = tgt_r;
    pos_nxt = pos_r;
    rec_nxt = rec_r;
    step_nxt = step_r;
    dir_nxt = dir_r;
    done_nxt = 1'b0;
    fault_nxt = fault_r;
    unique case (st_r)
      SP_IDLE: if (go) begin
        pos_nxt = cur;
        tgt_nxt = tgt;
        rec_nxt = recal;
        nst_nxt = '0;
        fault_nxt = 1'b0;
        st_nxt = SP_CHECK;
      end
      SP_CHECK: if (rec_r ? track_zero : (pos_r == tgt_r)) begin
        done_nxt = 1'b1;
        if (rec_r) begin
          pos_nxt = '0;
        end
        st_nxt = SP_IDLE;
      end else if (rec_r && nst_r == RECAL_MAX_STEPS) begin
        done_nxt = 1'b1;
        fault_nxt = 1'b1;
        st_nxt = SP_IDLE;
      end else begin
        dir_nxt = !rec_r && (tgt_r > pos_r);
        step_nxt = 1'b1;
        tmr_nxt = TW'(STEP_PULSE_CYC - 1);
        st_nxt = SP_PULSE;
      end
      SP_PULSE: if (tmr_r == '0) begin
        step_nxt = 1'b0;
        nst_nxt = nst_r + 7'h1;
        if (!rec_r) begin
          pos_nxt = dir_r ? pos_r + 8'h1 : pos_r - 8'h1;
        end
        tmr_nxt = TW'(gap_ms * MS_CYC);
        st_nxt = SP_GAP;
      end else begin
        tmr_nxt = tmr_r - TW'(1);
      end
      SP_GAP: if (tmr_r == '0) begin
        st_nxt = SP_CHECK;
      end else begin
        tmr_nxt = tmr_r - TW'(1);
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r <= SP_IDLE;
      tmr_r <= '0;
      nst_r <= '0;
      tgt_r <= '0;
      pos_r <= '0;
      rec_r <= 1'b0;
      step_r <= 1'b0;
      dir_r <= 1'b0;
      done_r <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      nst_r <= nst_nxt;
      tgt_r <= tgt_nxt;
      pos_r <= pos_nxt;
      rec_r <= rec_nxt;
      step_r <= step_nxt;
      dir_r <= dir_nxt;
      done_r <= done_nxt;
      fault_r <= fault_nxt;
    end
  end

  property p_recal_limit;
    @(posedge ref_clk) disable iff (sys_rst)
    (st_r == SP_CHECK && rec_r && !track_zero && nst_r == RECAL_MAX_STEPS)
      |=> (done_r && fault_r);
  endproperty
  a_recal_limit: assert property (p_recal_limit) else $error("no fault after 80 steps");
endmodule // dcp_stepper

// ==== dcp_ctrl.sv ====
// Command, execution and result phases of the diskette command interpreter.
`timescale 1ns/10ps
module dcp_ctrl #(
  parameter int FIFO_DEPTH = 8,
  parameter int MS_CYC = dcp_pkg::MS_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  input wire logic host_rd,
  output logic [7:0] host_rdata_r,
  output logic req_master_r,
  output logic dir_to_host_r,
  output logic busy_r,
  output logic exec_start_r,
  output logic [8:0][7:0] cmd_bytes_r,
  output logic multitrack_flag_r,
  output logic density_mode_flag_r,
  output logic skip_deleted_flag_r,
  output logic head_number_r,
  output logic [1:0] drive_pick_r,
  input wire logic exec_done,
  input wire logic exec_fail,
  input wire logic [7:0] exec_st1,
  input wire logic [7:0] exec_st2,
  input wire logic [7:0] exec_cyl,
  input wire logic [7:0] exec_head,
  input wire logic [7:0] exec_sector,
  input wire logic [7:0] exec_size,
  output logic [3:0] step_rate_r,
  output logic [3:0] head_unload_time_r,
  output logic [6:0] head_load_time_r,
  output logic non_transfer_mode_r,
  input wire logic track_zero,
  input wire logic write_protect,
  output logic step_pulse_r,
  output logic step_dir_r
);
  import dcp_pkg::*;

  function automatic dcp_cmd_t decode(input logic [7:0] b);
    decode = CMD_BAD;
    if (b[4:0] == OPC_RDATA) decode = CMD_RDATA;
    if (b[4:0] == OPC_RDEL) decode = CMD_RDEL;
    if ((b & MASK_Z75) == 8'h00 && b[4:0] == OPC_RTRK) decode = CMD_RTRK;
    if ((b & MASK_Z75) == 8'h00 && b[4:0] == OPC_RID) decode = CMD_RID;
    if (!b[SK_BIT] && b[4:0] == OPC_WDATA) decode = CMD_WDATA;
    if (!b[SK_BIT] && b[4:0] == OPC_WDEL) decode = CMD_WDEL;
    if ((b & MASK_Z75) == 8'h00 && b[4:0] == OPC_FMT) decode = CMD_FMT;
    if (b == OPC_RECAL) decode = CMD_RECAL;
    if (b == OPC_SINT) decode = CMD_SINT;
    if (b == OPC_SPEC) decode = CMD_SPEC;
    if (b == OPC_SDRV) decode = CMD_SDRV;
    if (b == OPC_SEEK) decode = CMD_SEEK;
  endfunction

  function automatic logic [3:0] par_len(input dcp_cmd_t c);
    unique case (c)
      CMD_RDATA, CMD_RDEL, CMD_RTRK, CMD_WDATA, CMD_WDEL: par_len = LEN_XFER;
      CMD_FMT: par_len = LEN_FMT;
      CMD_SPEC, CMD_SEEK: par_len = LEN_TWO;
      CMD_RID, CMD_RECAL, CMD_SDRV: par_len = LEN_ONE;
      CMD_SINT, CMD_BAD: par_len = LEN_NONE;
    endcase
  endfunction

  dcp_phase_t ph_r, ph_nxt;
  dcp_cmd_t cmd_r, cmd_nxt;
  logic [8:0][7:0] cb_nxt;
  logic [3:0] pidx_r, pidx_nxt, plen_r, plen_nxt;
  logic [6:0][7:0] res_r, res_nxt;
  logic [2:0] rlen_r, rlen_nxt, ridx_r, ridx_nxt;
  logic [3:0][7:0] pcn_r, pcn_nxt;
  logic pend_r, pend_nxt;
  logic [7:0] ist0_r, ist0_nxt, ipcn_r, ipcn_nxt, rdata_nxt;
  logic rqm_nxt, dio_nxt, busy_nxt, xs_nxt, mt_nxt, mf_nxt, sk_nxt, hd_nxt;
  logic [1:0] drv_nxt;
  logic [3:0] srt_nxt, hut_nxt;
  logic [6:0] hlt_nxt;
  logic nd_nxt, pop, stp_go, f_in_ready, f_valid, stp_done, stp_fault;
  logic [7:0] f_data, stp_pos;
  logic [$clog2(FIFO_DEPTH):0] f_level;

  dcp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_valid(host_wr),
    .in_data(host_wdata),
    .in_ready(f_in_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(pop),
    .level(f_level)
  );

  dcp_stepper #(.MS_CYC(MS_CYC)) u_step (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .go(stp_go),
    .recal(cmd_r == CMD_RECAL),
    // Next-value taps: the last parameter byte is popped in the same cycle as go
    .cur(pcn_r[drv_nxt]),
    .tgt((cmd_r == CMD_SEEK) ? cb_nxt[2] : 8'h00),
    .rate(step_rate_r),
    .track_zero(track_zero),
    .step_r(step_pulse_r),
    .dir_r(step_dir_r),
    .done_r(stp_done),
    .fault_r(stp_fault),
    .pos_r(stp_pos)
  );

  always_comb begin
    ph_nxt = ph_r;
    cmd_nxt = cmd_r;
    cb_nxt = cmd_bytes_r;
    pidx_nxt = pidx_r;
    plen_nxt = plen_r;
    res_nxt = res_r;
    rlen_nxt = rlen_r;
    ridx_nxt = ridx_r;
    pcn_nxt = pcn_r;
    pend_nxt = pend_r;
    ist0_nxt = ist0_r;
    ipcn_nxt = ipcn_r;
    rdata_nxt = host_rdata_r;
    mt_nxt = multitrack_flag_r;
    mf_nxt = density_mode_flag_r;
    sk_nxt = skip_deleted_flag_r;
    hd_nxt = head_number_r;
    drv_nxt = drive_pick_r;
    srt_nxt = step_rate_r;
    hut_nxt = head_unload_time_r;
    hlt_nxt = head_load_time_r;
    nd_nxt = non_transfer_mode_r;
    xs_nxt = 1'b0;
    stp_go = 1'b0;
    pop = 1'b0;
    unique case (ph_r)
      PH_CMD: if (f_valid) begin
        pop = 1'b1;
        cb_nxt = '0;
        cb_nxt[0] = f_data;
        cmd_nxt = decode(f_data);
        plen_nxt = par_len(cmd_nxt);
        pidx_nxt = 4'h1;
        mt_nxt = f_data[MT_BIT] && cmd_nxt inside {CMD_RDATA, CMD_RDEL, CMD_WDATA, CMD_WDEL};
        mf_nxt = f_data[MF_BIT] && cmd_nxt <= CMD_FMT;
        sk_nxt = f_data[SK_BIT] && cmd_nxt inside {CMD_RDATA, CMD_RDEL};
        if (cmd_nxt == CMD_BAD) begin
          res_nxt[0] = dcp_st0(TC_INVALID, 1'b0, 1'b0, 1'b0, 2'h0);
          rlen_nxt = RES_ONE;
          ph_nxt = PH_RES;
        end else if (cmd_nxt == CMD_SINT) begin
          res_nxt[0] = pend_r ? ist0_r : dcp_st0(TC_INVALID, 1'b0, 1'b0, 1'b0, 2'h0);
          res_nxt[1] = ipcn_r;
          rlen_nxt = pend_r ? RES_SINT : RES_ONE;
          pend_nxt = 1'b0;
          ph_nxt = PH_RES;
        end else begin
          ph_nxt = PH_PAR;
        end
      end
      PH_PAR: if (f_valid) begin
        pop = 1'b1;
        cb_nxt[pidx_r] = f_data;
        pidx_nxt = pidx_r + 4'h1;
        // Only head and drive bits used, and only the drive bits for recalibrate
        if (pidx_r == 4'h1 && cmd_r != CMD_SPEC) begin
          hd_nxt = (cmd_r == CMD_RECAL) ? 1'b0 : f_data[HD_BIT];
          drv_nxt = f_data[1:0];
        end
        if (pidx_r == plen_r) begin
          unique case (cmd_r)
            CMD_SPEC: begin
              srt_nxt = cb_nxt[1][7:4];
              hut_nxt = cb_nxt[1][3:0];
              hlt_nxt = cb_nxt[2][7:1];
              nd_nxt = cb_nxt[2][0];
              ph_nxt = PH_CMD;
            end
            CMD_SDRV: begin
              res_nxt[0] = {1'b0, write_protect, 1'b0, track_zero, 1'b0, hd_nxt, drv_nxt};
              rlen_nxt = RES_ONE;
              ph_nxt = PH_RES;
            end
            CMD_SEEK, CMD_RECAL: begin
              stp_go = 1'b1;
              ph_nxt = PH_STEP;
            end
            default: begin
              xs_nxt = 1'b1;
              ph_nxt = PH_EXEC;
            end
          endcase
        end
      end
      PH_EXEC: if (exec_done) begin
        // Head and drive in status zero
        res_nxt[0] = dcp_st0(exec_fail ? TC_FAILED : TC_NORMAL, 1'b0, 1'b0,
                             head_number_r, drive_pick_r);
        res_nxt[1] = exec_st1;
        res_nxt[2] = exec_st2;
        res_nxt[3] = exec_cyl;
        res_nxt[4] = exec_head;
        res_nxt[5] = exec_sector;
        res_nxt[6] = exec_size;
        if (cmd_r == CMD_FMT) begin
          res_nxt[3] = 8'h00;
          res_nxt[4] = 8'h00;
          res_nxt[5] = 8'h00;
          res_nxt[6] = 8'h00;
        end
        rlen_nxt = RES_XFER;
        ph_nxt = PH_RES;
      end
      PH_STEP: if (stp_done) begin
        ist0_nxt = dcp_st0(stp_fault ? TC_FAILED : TC_NORMAL, 1'b1, stp_fault,
                           head_number_r, drive_pick_r);
        pcn_nxt[drive_pick_r] = stp_pos;
        ipcn_nxt = stp_pos;
        pend_nxt = 1'b1;
        ph_nxt = PH_CMD;
      end
      PH_RES: if (host_rd) begin
        if (ridx_r == rlen_r - 3'h1) begin
          ridx_nxt = '0;
          ph_nxt = PH_CMD;
        end else begin
          ridx_nxt = ridx_r + 3'h1;
          rdata_nxt = res_r[ridx_nxt];
        end
      end
    endcase
    if (ph_nxt == PH_RES && ph_r != PH_RES) begin
      rdata_nxt = res_nxt[0];
      ridx_nxt = '0;
    end
    // Ready keeps headroom for one in-flight write
    rqm_nxt = (ph_nxt == PH_RES) ||
              (ph_nxt inside {PH_CMD, PH_PAR} && 32'(f_level) <= FIFO_DEPTH - 2 && f_in_ready);
    dio_nxt = (ph_nxt == PH_RES);
    busy_nxt = (ph_nxt != PH_CMD);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ph_r <= PH_CMD;
      cmd_r <= CMD_BAD;
      cmd_bytes_r <= '0;
      pidx_r <= '0;
      plen_r <= '0;
      res_r <= '0;
      rlen_r <= '0;
      ridx_r <= '0;
      pcn_r <= '0;
      pend_r <= 1'b0;
      ist0_r <= '0;
      ipcn_r <= '0;
      host_rdata_r <= '0;
      req_master_r <= 1'b0;
      dir_to_host_r <= 1'b0;
      busy_r <= 1'b0;
      exec_start_r <= 1'b0;
      multitrack_flag_r <= 1'b0;
      density_mode_flag_r <= 1'b0;
      skip_deleted_flag_r <= 1'b0;
      head_number_r <= 1'b0;
      drive_pick_r <= '0;
      step_rate_r <= '0;
      head_unload_time_r <= '0;
      head_load_time_r <= '0;
      non_transfer_mode_r <= 1'b0;
    end else begin
      ph_r <= ph_nxt;
      cmd_r <= cmd_nxt;
      cmd_bytes_r <= cb_nxt;
      pidx_r <= pidx_nxt;
      plen_r <= plen_nxt;
      res_r <= res_nxt;
      rlen_r <= rlen_nxt;
      ridx_r <= ridx_nxt;
      pcn_r <= pcn_nxt;
      pend_r <= pend_nxt;
      ist0_r <= ist0_nxt;
      ipcn_r <= ipcn_nxt;
      host_rdata_r <= rdata_nxt;
      req_master_r <= rqm_nxt;
      dir_to_host_r <= dio_nxt;
      busy_r <= busy_nxt;
      exec_start_r <= xs_nxt;
      multitrack_flag_r <= mt_nxt;
      density_mode_flag_r <= mf_nxt;
      skip_deleted_flag_r <= sk_nxt;
      head_number_r <= hd_nxt;
      drive_pick_r <= drv_nxt;
      step_rate_r <= srt_nxt;
      head_unload_time_r <= hut_nxt;
      head_load_time_r <= hlt_nxt;
      non_transfer_mode_r <= nd_nxt;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_exec_end;
    ph_r == PH_EXEC && exec_done;
  endsequence
  sequence s_step_end;
    ph_r == PH_STEP && stp_done;
  endsequence
  property p_invalid;
    (ph_r == PH_CMD && f_valid && decode(f_data) == CMD_BAD)
      |=> (ph_r == PH_RES && rlen_r == RES_ONE && host_rdata_r == 8'h80);
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid opcode result wrong");
  property p_xfer_res;
    s_exec_end |=> (rlen_r == RES_XFER && dir_to_host_r && res_r[0][3] == 1'b0);
  endproperty
  a_xfer_res: assert property (p_xfer_res) else $error("transfer result wrong");
  property p_fmt_res;
    (s_exec_end ##0 cmd_r == CMD_FMT) |=> (res_r[3] == 8'h00 && res_r[6] == 8'h00);
  endproperty
  a_fmt_res: assert property (p_fmt_res) else $error("format reserved bytes nonzero");
  property p_step_end;
    s_step_end |=> (ph_r == PH_CMD && pend_r && ist0_r[5] && !dir_to_host_r);
  endproperty
  a_step_end: assert property (p_step_end) else $error("seek end not flagged");
  property p_fault_code;
    (s_step_end ##0 stp_fault) |=> (ist0_r[7:6] == TC_FAILED && ist0_r[4]);
  endproperty
  a_fault_code: assert property (p_fault_code) else $error("fault code wrong");
  property p_sint;
    (ph_r == PH_CMD && f_valid && f_data == OPC_SINT && pend_r)
      |=> (rlen_r == RES_SINT && res_r[1] == $past(ipcn_r) && !pend_r);
  endproperty
  a_sint: assert property (p_sint) else $error("interrupt query result wrong");
  property p_spec;
    (ph_r == PH_PAR && cmd_r == CMD_SPEC && f_valid && pidx_r == plen_r)
      |=> (ph_r == PH_CMD && non_transfer_mode_r == $past(f_data[0]));
  endproperty
  a_spec: assert property (p_spec) else $error("timing setup wrong");
  property p_start;
    $rose(exec_start_r) |-> (ph_r == PH_EXEC) ##1 !exec_start_r;
  endproperty
  a_start: assert property (p_start) else $error("execution start not a pulse");
  property p_sdrv;
    (ph_r == PH_PAR && cmd_r == CMD_SDRV && f_valid)
      |=> (rlen_r == RES_ONE && host_rdata_r[6] == $past(write_protect));
  endproperty
  a_sdrv: assert property (p_sdrv) else $error("drive status wrong");
endmodule // dcp_ctrl

// ==== dcp_host.sv ====
// Host processor model: writes command bytes and reads result bytes.
`timescale 1ns/10ps
module dcp_host (
  input wire logic ref_clk,
  input wire logic req_master_r,
  input wire logic dir_to_host_r,
  input wire logic [7:0] host_rdata_r,
  output logic host_wr,
  output logic [7:0] host_wdata,
  output logic host_rd
);
  initial begin
    host_wr = 1'b0;
    host_wdata = 8'h00;
    host_rd = 1'b0;
  end
  task automatic ready(input logic d);
    int n;
    n = 0;
    while (!(req_master_r === 1'b1 && dir_to_host_r === d) && n < 9000) begin
      @(posedge ref_clk) #1;
      n++;
    end
    if (n >= 9000) testbench.timeout();
  endtask
  // Idle cycle after each strobe; released data is inverted so stale bytes never match
  task automatic send(input logic [7:0] b);
    ready(1'b0);
    host_wr = 1'b1;
    host_wdata = b;
    @(posedge ref_clk) #1;
    host_wr = 1'b0;
    host_wdata = ~b;
    @(posedge ref_clk) #1;
  endtask
  task automatic recv(output logic [7:0] b);
    ready(1'b1);
    b = host_rdata_r;
    host_rd = 1'b1;
    @(posedge ref_clk) #1;
    host_rd = 1'b0;
    @(posedge ref_clk) #1;
  endtask
endmodule // dcp_host

// ==== testbench.sv ====
// Self-checking bench for the diskette command interpreter.
`timescale 1ns/10ps
module testbench;
  import dcp_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1, exec_done = 1'b0, track_zero = 1'b1;
  logic host_wr, host_rd, req_master_r, dir_to_host_r, busy_r, exec_start_r;
  logic non_transfer_mode_r;
  logic [7:0] host_wdata, host_rdata_r, st = 8'h3C, b;
  logic [3:0] step_rate_r, head_unload_time_r;
  logic [6:0] head_load_time_r;
  logic multitrack_flag_r, density_mode_flag_r, skip_deleted_flag_r, head_number_r;
  logic step_pulse_r, step_dir_r, exec_fail = 1'b0, write_protect = 1'b0, last_dir = 1'b0;
  logic [1:0] drive_pick_r;
  logic [8:0][7:0] cmd_bytes_r;
  logic [7:0] flg, hdrv;
  int error_cnt = 0, n_compared = 0, n_steps = 0;
  always #20 ref_clk = ~ref_clk;
  dcp_ctrl #(.MS_CYC(4)) dut (.ref_clk, .sys_rst, .host_wr, .host_wdata, .host_rd,
    .host_rdata_r, .req_master_r, .dir_to_host_r, .busy_r, .exec_start_r, .cmd_bytes_r,
    .multitrack_flag_r, .density_mode_flag_r, .skip_deleted_flag_r, .head_number_r,
    .drive_pick_r, .exec_done, .exec_fail, .exec_st1(st), .exec_st2(~st),
    .exec_cyl(st + 8'h01), .exec_head(st + 8'h02), .exec_sector(st + 8'h03),
    .exec_size(st + 8'h04), .step_rate_r, .head_unload_time_r, .head_load_time_r,
    .non_transfer_mode_r, .track_zero, .write_protect, .step_pulse_r, .step_dir_r);
  assign flg = {5'h00, multitrack_flag_r, density_mode_flag_r, skip_deleted_flag_r};
  assign hdrv = {5'h00, head_number_r, drive_pick_r};
  // Direction is judged at the trailing edge, where the drive takes it
  always @(negedge step_pulse_r) begin
    if (!sys_rst) begin
      n_steps++;
      last_dir = step_dir_r;
    end
  end
  dcp_host host (.ref_clk, .req_master_r, .dir_to_host_r, .host_rdata_r, .host_wr,
    .host_wdata, .host_rd);
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic conclude();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic timeout();
    error_cnt++;
    conclude();
  endtask
  task automatic t_invalid();
    logic [7:0] bad [3];
    bad = '{8'hFF, 8'hE2, 8'h25};
    foreach (bad[i]) begin
      host.send(bad[i]);
      host.recv(b);
      chk("invalid st0", 8'h80, b);
    end
    chk("invalid done", 8'h00, {7'h00, dir_to_host_r});
  endtask
  task automatic t_timing();
    host.send(8'h03);
    host.send(8'hA5);
    host.send(8'h0B);
    repeat (4) @(posedge ref_clk) #1;
    chk("timing", 8'hA5, {step_rate_r, head_unload_time_r});
    chk("load", 8'h0B, {head_load_time_r, non_transfer_mode_r});
    chk("no result", 8'h00, {7'h00, dir_to_host_r});
    chk("idle busy", 8'h00, {7'h00, busy_r});
  endtask
  // Engine handshake shared by transfers: start pulse, completion, seven results
  task automatic xfer(input logic [7:0] op, input int np, input logic [7:0] p1,
                      input logic fl, input logic [7:0] e0);
    logic [7:0] e [7];
    int n;
    st = op ^ 8'h5A;
    e = '{e0, st, ~st, st + 8'h01, st + 8'h02, st + 8'h03, st + 8'h04};
    host.send(op);
    host.send(p1);
    for (int i = 2; i <= np; i++) begin
      host.send(8'h10 + 8'(i));
    end
    n = 0;
    while (exec_start_r !== 1'b1 && n < 200) begin
      @(posedge ref_clk) #1;
      n++;
    end
    if (n >= 200) timeout();
    chk("last param", (np > 1) ? 8'h10 + 8'(np) : p1, cmd_bytes_r[np]);
    exec_done = 1'b1;
    exec_fail = fl;
    @(posedge ref_clk) #1;
    exec_done = 1'b0;
    exec_fail = 1'b0;
    for (int i = 0; i < 7; i++) begin
      host.recv(b);
      if (op[4:0] == 5'h0D && i > 2) begin
        chk("format reserved", 8'h00, b);
      end else begin
        chk("result", e[i], b);
      end
    end
  endtask
  task automatic t_read_id();
    xfer(8'h4A, 1, 8'hFD, 1'b0, 8'h05);
    chk("id flags", 8'h02, flg);
    chk("id head drive", 8'h05, hdrv);
  endtask
  task automatic t_reads();
    xfer(8'hE6, 8, 8'hF8, 1'b1, 8'h40);
    chk("read flags", 8'h07, flg);
    xfer(8'h2C, 8, 8'h06, 1'b0, 8'h06);
    chk("deleted read flags", 8'h01, flg);
    xfer(8'h02, 8, 8'h03, 1'b0, 8'h03);
    chk("track flags", 8'h00, flg);
  endtask
  task automatic t_writes();
    xfer(8'hC5, 8, 8'h01, 1'b0, 8'h01);
    chk("write flags", 8'h06, flg);
    xfer(8'h49, 8, 8'h02, 1'b0, 8'h02);
    chk("deleted write flags", 8'h02, flg);
    xfer(8'h4D, 5, 8'h04, 1'b0, 8'h04);
    chk("format flags", 8'h02, flg);
  endtask
  task automatic t_drive();
    write_protect = 1'b1;
    host.send(8'h04);
    host.send(8'hFE);
    host.recv(b);
    write_protect = 1'b0;
    chk("drive status", 8'h56, b);
  endtask
  task automatic t_seek();
    host.send(8'h0F);
    host.send(8'h01);
    host.send(8'h05);
    host.send(8'h08);
    host.recv(b);
    chk("seek st0", 8'h21, b);
    host.recv(b);
    chk("cylinder", 8'h05, b);
    chk("seek steps", 8'h05, 8'(n_steps));
    chk("seek dir", 8'h01, {7'h00, last_dir});
  endtask
  task automatic t_recal_fault();
    track_zero = 1'b0;
    host.send(8'h07);
    host.send(8'h02);
    host.send(8'h08);
    host.recv(b);
    chk("recal st0", 8'h72, b);
    chk("recal steps", 8'h55, 8'(n_steps));
    chk("recal dir", 8'h00, {7'h00, last_dir});
    host.recv(b);
    host.send(8'h08);
    host.recv(b);
    chk("none pending", 8'h80, b);
    track_zero = 1'b1;
    host.send(8'h07);
    host.send(8'h01);
    host.send(8'h08);
    host.recv(b);
    chk("recal end st0", 8'h21, b);
    host.recv(b);
    chk("recal cylinder", 8'h00, b);
  endtask
  task automatic t_reset();
    host.send(8'h03);
    sys_rst = 1'b1;
    repeat (2) @(posedge ref_clk) #1;
    sys_rst = 1'b0;
    chk("reset state", 8'h00, {3'h0, busy_r, step_rate_r});
    host.send(8'h08);
    host.recv(b);
    chk("reset pending", 8'h80, b);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    t_invalid();
    t_timing();
    t_read_id();
    t_reads();
    t_writes();
    t_drive();
    t_seek();
    t_recal_fault();
    t_reset();
    conclude();
  end
endmodule // testbench
